// ==== hdl/adcsr_pkg.sv ====
// Contract
// - each word preceded by header zero one zero
// - leading header zero driven once msb ready
// - header one, zero on first two falls
// - no data clock returned with serial data
// - running conversion ignores further start pulses
// - unfinished burst loses result to next conversion
// - later falls advance the sixteen data bits
// - conversion starts on start signal rising edge
// - first result after power-up is invalid
// - result is sixteen data bits after header
// - result sent msb first, msb by msb ready
`default_nettype none
package adcsr_pkg;
   localparam int unsigned CLK_PERIOD_NS       = 40;
   localparam int unsigned MSB_READY_TIME_NS   = 200;
   localparam int unsigned BURST_DEADLINE_NS   = 40;
   localparam int unsigned CONVERSION_TIME_NS  = 80;
   localparam int unsigned MSB_READY_CYC       =
      (MSB_READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BURST_DEADLINE_CYC  =
      (BURST_DEADLINE_NS / CLK_PERIOD_NS) < 1 ? 1 : BURST_DEADLINE_NS / CLK_PERIOD_NS;
   localparam int unsigned CONV_CYC            =
      (CONVERSION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DATA_BITS           = 16;
   localparam int unsigned FRAME_BITS          = 18;
   localparam logic [2:0]  HEADER_PATTERN      = 3'h2;
   localparam logic [15:0] RESULT_RESET        = 16'h0000;
   localparam logic [4:0]  TIMER_RESET         = 5'h00;
   typedef enum logic [1:0] {ADCSR_IDLE, ADCSR_CONVERT, ADCSR_WAIT_MSB, ADCSR_READY} adcsr_state_t;
   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } adcsr_result_t;
endpackage : adcsr_pkg
`default_nettype wire

// ==== hdl/adcsr_sync.sv ====
`default_nettype none
module adcsr_sync
   import adcsr_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic async_in,
   output var  logic sync_out
);
   logic stage1;
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         stage1   <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : adcsr_sync
`default_nettype wire

// ==== hdl/adcsr_readout.sv ====
`default_nettype none
module adcsr_readout
   import adcsr_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          reset_n,
   input  wire logic          conversion_start_pair,
   input  wire logic          serial_clock,
   input  wire adcsr_result_t sample,
   output var  logic          serial_data,
   output var  logic          converting,
   output var  logic          result_lost
);
   adcsr_state_t  state;
   logic          start_s;
   logic          start_d;
   logic          sclk_s;
   logic          sclk_d;
   logic [4:0]    timer;
   logic [4:0]    edge_count;
   logic [17:0]   shifter;
   logic          seen_first;
   logic          burst_done;
   logic          start_rise;
   logic          sclk_fall;

   adcsr_sync u_start_sync (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .async_in (conversion_start_pair),
      .sync_out (start_s)
   );

   adcsr_sync u_sclk_sync (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .async_in (serial_clock),
      .sync_out (sclk_s)
   );

   // edge detection on synchronised levels
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         start_d <= 1'b0;
         sclk_d  <= 1'b0;
      end
      else
      begin
         start_d <= start_s;
         sclk_d  <= sclk_s;
      end
   end

   assign start_rise = start_s && !start_d;
   assign sclk_fall  = sclk_d && !sclk_s;

   // conversion sequencing
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state      <= ADCSR_IDLE;
         timer      <= TIMER_RESET;
         converting <= 1'b0;
      end
      else
      begin
         case (state)
            ADCSR_IDLE, ADCSR_READY:
            begin
               if (start_rise)
               begin
                  state      <= ADCSR_CONVERT;
                  timer      <= TIMER_RESET;
                  converting <= 1'b1;
               end
            end
            ADCSR_CONVERT:
            begin
               // starts are not looked at here
               timer <= timer + 5'h01;
               if (timer == 5'(CONV_CYC - 1))
               begin
                  state <= ADCSR_WAIT_MSB;
               end
            end
            ADCSR_WAIT_MSB:
            begin
               timer <= timer + 5'h01;
               if (timer == 5'(MSB_READY_CYC - 1))
               begin
                  state      <= ADCSR_READY;
                  converting <= 1'b0;
               end
            end
            default:
            begin
               state <= ADCSR_IDLE;
            end
         endcase
      end
   end

   // output shifter: header 010 then sixteen bits msb first
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         shifter     <= {HEADER_PATTERN[2:1], RESULT_RESET};
         serial_data <= 1'b0;
         edge_count  <= TIMER_RESET;
         burst_done  <= 1'b1;
         seen_first  <= 1'b0;
         result_lost <= 1'b0;
      end
      else if (state == ADCSR_WAIT_MSB && timer == 5'(MSB_READY_CYC - 1))
      begin
         // load overwrites any unfinished burst
         result_lost <= !burst_done && seen_first;
         shifter     <= {HEADER_PATTERN[1:0], sample.word};
         serial_data <= HEADER_PATTERN[2];
         edge_count  <= TIMER_RESET;
         burst_done  <= 1'b0;
         seen_first  <= 1'b1;
      end
      else if (sclk_fall && !burst_done)
      begin
         serial_data <= shifter[17];
         shifter     <= {shifter[16:0], 1'b0};
         edge_count  <= edge_count + 5'h01;
         if (edge_count == 5'(FRAME_BITS - 1))
         begin
            burst_done <= 1'b1;
         end
      end
   end
   // serial_data, converting and result_lost leave; no clock is echoed
endmodule : adcsr_readout
`default_nettype wire

// ==== bench/adcsr_sva.sv ====
`default_nettype none
module adcsr_sva
   import adcsr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic conversion_start_pair,
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic converting,
   input wire logic result_lost
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_go; $rose(converting) |-> $past(conversion_start_pair, 2); endproperty
   a_go: assert property (p_go) else $error("go");
   property p_len; $rose(converting) |-> converting[*5] ##1 !converting; endproperty
   a_len: assert property (p_len) else $error("len");
   property p_msb; $fell(converting) |-> $past(converting, 5) && !$past(converting, 6);
   endproperty
   a_msb: assert property (p_msb) else $error("msb");
   property p_hdr; $fell(converting) |-> !serial_data; endproperty
   a_hdr: assert property (p_hdr) else $error("hdr");
   property p_step; $changed(serial_data) |-> $fell(converting) || !$past(serial_clock, 2)
      && ($past(serial_clock, 3) || $past(serial_clock, 4) || $past(serial_clock, 5)); endproperty
   a_step: assert property (p_step) else $error("step");
   property p_lost; $rose(result_lost) |-> $fell(converting); endproperty
   a_lost: assert property (p_lost) else $error("lost");
   property p_clr; $fell(result_lost) |-> $fell(converting); endproperty
   a_clr: assert property (p_clr) else $error("clr");
   property p_gap; $fell(converting) |=> !converting[*2]; endproperty
   a_gap: assert property (p_gap) else $error("gap");
   c_lost: cover property ($rose(result_lost));
   c_bit: cover property ($rose(serial_data));
   c_conv: cover property ($fell(converting));
endmodule : adcsr_sva
bind adcsr_readout adcsr_sva u_sva (.mclk, .reset_n, .conversion_start_pair, .serial_clock,
   .serial_data, .converting, .result_lost);
`default_nettype wire

// ==== bench/adcsr_host.sv ====
`default_nettype none
module adcsr_host
   import adcsr_pkg::*;
(
   input  wire logic mclk,
   input  wire logic serial_data,
   output var  logic serial_clock
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [17:0] frame;
   initial serial_clock = 1'b1;
   task automatic burst(input int n);
      frame = '0;
      repeat (n)
      begin
         repeat (4) @(negedge mclk);
         serial_clock = 1'b0;
         repeat (4) @(negedge mclk);
         serial_clock = 1'b1;
         frame = {frame[16:0], serial_data};
      end
   endtask : burst
endmodule : adcsr_host
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import adcsr_pkg::*;
   logic mclk, reset_n, go, sd, cv, lost;
   wire logic sclk;
   adcsr_result_t smp;
   int errors, n_checks;
   adcsr_readout DUT (.mclk, .reset_n, .conversion_start_pair(go), .serial_clock(sclk),
      .sample(smp), .serial_data(sd), .converting(cv), .result_lost(lost));
   adcsr_host host (.mclk, .serial_data(sd), .serial_clock(sclk));
   initial
   begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end
   task automatic check(input logic [17:0] s, input logic [17:0] e);
      n_checks++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] %0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic convert(input logic [15:0] w, input bit again);
      int i;
      smp = {1'b1, w};
      go = 1;
      repeat (4) @(negedge mclk);
      check(18'(cv), 18'h1);
      go = 0;
      if (again)
      begin
         @(negedge mclk) go = 1;
         @(negedge mclk) go = 0;
      end
      for (i = 0; i < 40 && cv !== 1'b0; i++) @(negedge mclk);
      check(18'(i < 40), 18'h1);
      if (i == 40)
         stop_test();
      check(18'(sd), 18'h0);
   endtask : convert
   task automatic t_frame(input logic [15:0] w, input bit again);
      convert(w, again);
      host.burst(18);
      check(host.frame, {2'h2, w});
      check(18'(cv), 18'h0);
      $display("frame %h done", w);
   endtask : t_frame
   task automatic t_lost;
      convert(16'h1111, 0);
      host.burst(5);
      convert(16'h2222, 0);
      check(18'(lost), 18'h1);
      host.burst(18);
      check(host.frame, {2'h2, 16'h2222});
      convert(16'h3333, 0);
      check(18'(lost), 18'h0);
      host.burst(18);
      check(host.frame, {2'h2, 16'h3333});
      $display("lost done");
   endtask : t_lost
   initial
   begin
      errors = 0;
      n_checks = 0;
      go = 0;
      smp = '0;
      reset_n = 0;
      repeat (5) @(negedge mclk);
      reset_n = 1;
      convert(16'h0000, 0);
      check(18'(lost), 18'h0);
      host.burst(18);
      t_frame(16'h8001, 0);
      t_frame(16'h7ffe, 1);
      t_lost();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
